// file: iocx_pkg.sv
// Package of opcodes, vectors and state codes for the I/O and control unit.
package iocx_pkg;
    localparam logic [7:0] OP_PREFIX = 8'hED;
    localparam logic [7:0] OP_NOP = 8'h00;
    localparam logic [7:0] OP_HALT = 8'h76;
    localparam logic [7:0] OP_LOCK = 8'hF3;
    localparam logic [7:0] OP_UNLOCK = 8'hFB;
    localparam logic [7:0] OP_IN_IMM = 8'hDB;
    localparam logic [7:0] OP_OUT_IMM = 8'hD3;
    localparam logic [7:0] OP_IM0 = 8'h46;
    localparam logic [7:0] OP_IM1 = 8'h56;
    localparam logic [7:0] OP_IM2 = 8'h5E;
    localparam logic [7:0] OP_IN_REG_BASE = 8'h40;
    localparam logic [7:0] OP_OUT_REG_BASE = 8'h41;
    localparam logic [7:0] OP_IN_INC = 8'hA2;
    localparam logic [7:0] OP_IN_INC_REP = 8'hB2;
    localparam logic [7:0] OP_IN_DEC = 8'hAA;
    localparam logic [7:0] OP_IN_DEC_REP = 8'hBA;
    localparam logic [7:0] OP_OUT_INC = 8'hA3;
    localparam logic [7:0] OP_OUT_INC_REP = 8'hB3;
    localparam logic [7:0] OP_OUT_DEC = 8'hAB;
    localparam logic [7:0] OP_OUT_DEC_REP = 8'hBB;
    localparam logic [15:0] MODE1_TARGET = 16'h0038;
    localparam logic [15:0] PTR_STEP = 16'h0001;
    localparam logic [7:0] CNT_ONE = 8'h01;
    localparam logic [15:0] SP_RESET = 16'hFFFF;
    localparam logic [1:0] IM_0 = 2'h0;
    localparam logic [1:0] IM_1 = 2'h1;
    localparam logic [1:0] IM_2 = 2'h2;
    // Register file selector: count, port, D, E, H, L, accumulator.
    localparam logic [2:0] R_CNT = 3'h0;
    localparam logic [2:0] R_PORT = 3'h1;
    localparam logic [2:0] R_ACC = 3'h7;
    localparam logic [2:0] R_H = 3'h4;
    localparam logic [2:0] R_L = 3'h5;
    // Spare slot six holds the vector table base for mode 2.
    localparam logic [2:0] R_VEC = 3'h6;
    localparam int FIFO_DEPTH = 8;

    typedef enum logic [7:0] {
        ST_FETCH = 8'h01,
        ST_PREFIX = 8'h02,
        ST_PORTB = 8'h04,
        ST_IO = 8'h08,
        ST_HALTED = 8'h10,
        ST_PUSH = 8'h20,
        ST_VECLO = 8'h40,
        ST_VECHI = 8'h80
    } iocx_state_type;
endpackage

// file: iocx_unit.sv
// I/O and CPU control instruction execution unit with its data FIFO.
`timescale 1ns/1ps

// Small synchronous FIFO; ready on the write side is honest back-pressure.
module iocx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [WIDTH-1:0] wr_data,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [WIDTH-1:0] rd_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign wr_ready = (cnt_q != (AW+1)'(DEPTH));
    assign rd_valid = (cnt_q != '0);
    assign rd_data = mem[rp_q];
    assign push = wr_valid && wr_ready;
    assign pop = rd_valid && rd_ready;

    // Storage is written only on an accepted push.
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wp_q] <= wr_data;
        end
    end

    // Pointers wrap naturally since depth is a power of two.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // iocx_fifo

// Executes one instruction byte stream; input data passes through a FIFO.
module iocx_unit (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic instr_valid,
    output logic instr_ready,
    input wire logic [7:0] instr_byte,
    input wire logic int_req,
    input wire logic [7:0] int_data,
    input wire logic io_in_valid,
    output logic io_in_ready,
    input wire logic [7:0] io_in_data,
    input wire logic [7:0] mem_rd_data,
    output logic [15:0] io_addr_q,
    output logic [7:0] io_wdata_q,
    output logic io_rd_q,
    output logic io_wr_q,
    output logic [15:0] mem_addr_q,
    output logic [7:0] mem_wdata_q,
    output logic mem_rd_q,
    output logic mem_wr_q,
    output logic int_ack_q,
    output logic halted_q,
    output logic int_enable_q,
    output logic [1:0] int_mode_q,
    output logic [15:0] pc_q,
    output logic [15:0] memory_pointer_pair_q,
    output logic [7:0] count_q,
    output logic [7:0] acc_q
);
    iocx_pkg::iocx_state_type st_q;
    logic [7:0] regs_q [8];
    logic [7:0] op_q;
    logic [15:0] sp_q;
    logic [15:0] tgt_q;
    logic [7:0] veclo_q;
    logic push_hi_q;
    logic f_valid;
    logic f_ready;
    logic [7:0] f_data;
    logic take;
    logic blk;
    logic blk_in;
    logic blk_dec;
    logic blk_rep;
    logic reg_in;
    logic reg_out;
    logic [2:0] rsel;
    logic io_go;
    logic int_go;

    // Input data is buffered so the bus side can stall the peripheral.
    iocx_fifo #(.WIDTH(8), .DEPTH(iocx_pkg::FIFO_DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .wr_valid(io_in_valid),
        .wr_ready(io_in_ready),
        .wr_data(io_in_data),
        .rd_valid(f_valid),
        .rd_ready(f_ready),
        .rd_data(f_data)
    );

    // Second-byte decode of the register-indirect and block forms.
    always_comb begin
        rsel = op_q[5:3];
        reg_in = (op_q[7:6] == 2'b01) && (op_q[2:0] == 3'h0)
            && (rsel != 3'h6);
        reg_out = (op_q[7:6] == 2'b01) && (op_q[2:0] == 3'h1)
            && (rsel != 3'h6);
        blk = (op_q[7:5] == 3'b101) && (op_q[2:1] == 2'b01);
        blk_in = !op_q[0];
        blk_dec = op_q[3];
        blk_rep = op_q[4];
    end

    assign instr_ready = (st_q == iocx_pkg::ST_FETCH)
        || (st_q == iocx_pkg::ST_PREFIX) || (st_q == iocx_pkg::ST_PORTB);
    assign take = instr_valid && instr_ready && !int_go;
    // Interrupts are taken between instructions or out of the halted state.
    assign int_go = int_req && int_enable_q
        && ((st_q == iocx_pkg::ST_FETCH) || (st_q == iocx_pkg::ST_HALTED));
    // An input step waits for a byte; output steps never stall.
    assign io_go = (st_q == iocx_pkg::ST_IO)
        && (!(blk ? blk_in : (reg_in || op_q == iocx_pkg::OP_IN_IMM))
            || f_valid);
    assign f_ready = io_go && (blk ? blk_in
        : (reg_in || op_q == iocx_pkg::OP_IN_IMM));

    // Main sequencer: fetch, prefix, port byte, transfer, halt, interrupt.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_q <= iocx_pkg::ST_FETCH;
            op_q <= iocx_pkg::OP_NOP;
            pc_q <= '0;
            sp_q <= iocx_pkg::SP_RESET;
            tgt_q <= '0;
            veclo_q <= '0;
            push_hi_q <= 1'b0;
            int_enable_q <= 1'b0;
            int_mode_q <= iocx_pkg::IM_0;
            halted_q <= 1'b0;
            int_ack_q <= 1'b0;
            io_rd_q <= 1'b0;
            io_wr_q <= 1'b0;
            io_addr_q <= '0;
            io_wdata_q <= '0;
            mem_rd_q <= 1'b0;
            mem_wr_q <= 1'b0;
            mem_addr_q <= '0;
            mem_wdata_q <= '0;
            for (int i = 0; i < 8; i++) begin
                regs_q[i] <= '0;
            end
        end else begin
            io_rd_q <= 1'b0;
            io_wr_q <= 1'b0;
            mem_rd_q <= 1'b0;
            mem_wr_q <= 1'b0;
            int_ack_q <= 1'b0;
            if (int_go) begin
                // Acceptance ends a halt and locks further interrupts.
                halted_q <= 1'b0;
                int_enable_q <= 1'b0;
                int_ack_q <= 1'b1;
                if (int_mode_q == iocx_pkg::IM_0) begin
                    op_q <= int_data;
                    if (int_data == iocx_pkg::OP_PREFIX) begin
                        st_q <= iocx_pkg::ST_PREFIX;
                    end else if (int_data == iocx_pkg::OP_IN_IMM
                        || int_data == iocx_pkg::OP_OUT_IMM) begin
                        st_q <= iocx_pkg::ST_PORTB;
                    end else begin
                        st_q <= iocx_pkg::ST_FETCH;
                    end
                end else if (int_mode_q == iocx_pkg::IM_1) begin
                    tgt_q <= iocx_pkg::MODE1_TARGET;
                    push_hi_q <= 1'b1;
                    st_q <= iocx_pkg::ST_PUSH;
                end else begin
                    mem_addr_q <= {regs_q[iocx_pkg::R_VEC], int_data};
                    mem_rd_q <= 1'b1;
                    st_q <= iocx_pkg::ST_VECLO;
                end
            end else begin
                case (st_q)
                    iocx_pkg::ST_FETCH: begin
                        if (take) begin
                            pc_q <= pc_q + iocx_pkg::PTR_STEP;
                            op_q <= instr_byte;
                            case (instr_byte)
                                iocx_pkg::OP_PREFIX:
                                    st_q <= iocx_pkg::ST_PREFIX;
                                iocx_pkg::OP_IN_IMM,
                                iocx_pkg::OP_OUT_IMM:
                                    st_q <= iocx_pkg::ST_PORTB;
                                iocx_pkg::OP_HALT: begin
                                    halted_q <= 1'b1;
                                    st_q <= iocx_pkg::ST_HALTED;
                                end
                                iocx_pkg::OP_LOCK:
                                    int_enable_q <= 1'b0;
                                iocx_pkg::OP_UNLOCK:
                                    int_enable_q <= 1'b1;
                                default: ;
                            endcase
                        end
                    end
                    iocx_pkg::ST_PREFIX: begin
                        if (take) begin
                            pc_q <= pc_q + iocx_pkg::PTR_STEP;
                            op_q <= instr_byte;
                            st_q <= iocx_pkg::ST_FETCH;
                            case (instr_byte)
                                iocx_pkg::OP_IM0:
                                    int_mode_q <= iocx_pkg::IM_0;
                                iocx_pkg::OP_IM1:
                                    int_mode_q <= iocx_pkg::IM_1;
                                iocx_pkg::OP_IM2:
                                    int_mode_q <= iocx_pkg::IM_2;
                                default: begin
                                    if (instr_byte[7:6] == 2'b01
                                        && instr_byte[2:1] == 2'b00
                                        && instr_byte[5:3] != 3'h6) begin
                                        st_q <= iocx_pkg::ST_IO;
                                    end
                                    if (instr_byte[7:5] == 3'b101
                                        && instr_byte[2:1] == 2'b01) begin
                                        st_q <= iocx_pkg::ST_IO;
                                    end
                                end
                            endcase
                        end
                    end
                    iocx_pkg::ST_PORTB: begin
                        if (take) begin
                            pc_q <= pc_q + iocx_pkg::PTR_STEP;
                            veclo_q <= instr_byte;
                            st_q <= iocx_pkg::ST_IO;
                        end
                    end
                    iocx_pkg::ST_IO: begin
                        if (io_go) begin
                            if (op_q == iocx_pkg::OP_IN_IMM
                                || op_q == iocx_pkg::OP_OUT_IMM) begin
                                io_addr_q <= {acc_q, veclo_q};
                            end else begin
                                io_addr_q <= {count_q,
                                    regs_q[iocx_pkg::R_PORT]};
                            end
                            st_q <= iocx_pkg::ST_FETCH;
                            if (op_q == iocx_pkg::OP_IN_IMM) begin
                                io_rd_q <= 1'b1;
                                regs_q[iocx_pkg::R_ACC] <= f_data;
                            end else if (op_q == iocx_pkg::OP_OUT_IMM) begin
                                io_wr_q <= 1'b1;
                                io_wdata_q <= acc_q;
                            end else if (reg_in) begin
                                io_rd_q <= 1'b1;
                                regs_q[rsel] <= f_data;
                            end else if (reg_out) begin
                                io_wr_q <= 1'b1;
                                io_wdata_q <= regs_q[rsel];
                            end else begin
                                // Block step: one byte, count down by one.
                                mem_addr_q <= memory_pointer_pair_q;
                                if (blk_in) begin
                                    io_rd_q <= 1'b1;
                                    mem_wr_q <= 1'b1;
                                    mem_wdata_q <= f_data;
                                end else begin
                                    io_wr_q <= 1'b1;
                                    io_wdata_q <= mem_rd_data;
                                    mem_rd_q <= 1'b1;
                                end
                                regs_q[iocx_pkg::R_CNT] <=
                                    count_q - iocx_pkg::CNT_ONE;
                                // The pointer pair is the H and L registers.
                                {regs_q[iocx_pkg::R_H],
                                    regs_q[iocx_pkg::R_L]} <= blk_dec
                                    ? memory_pointer_pair_q - iocx_pkg::PTR_STEP
                                    : memory_pointer_pair_q + iocx_pkg::PTR_STEP;
                                if (blk_rep
                                    && count_q != iocx_pkg::CNT_ONE) begin
                                    st_q <= iocx_pkg::ST_IO;
                                end
                            end
                        end
                    end
                    iocx_pkg::ST_HALTED: ;
                    iocx_pkg::ST_VECLO: begin
                        tgt_q[7:0] <= mem_rd_data;
                        mem_addr_q <= mem_addr_q + iocx_pkg::PTR_STEP;
                        mem_rd_q <= 1'b1;
                        st_q <= iocx_pkg::ST_VECHI;
                    end
                    iocx_pkg::ST_VECHI: begin
                        tgt_q[15:8] <= mem_rd_data;
                        push_hi_q <= 1'b1;
                        st_q <= iocx_pkg::ST_PUSH;
                    end
                    iocx_pkg::ST_PUSH: begin
                        // Two stack writes, high byte first, then jump.
                        sp_q <= sp_q - iocx_pkg::PTR_STEP;
                        mem_addr_q <= sp_q - iocx_pkg::PTR_STEP;
                        mem_wr_q <= 1'b1;
                        mem_wdata_q <= push_hi_q ? pc_q[15:8] : pc_q[7:0];
                        push_hi_q <= 1'b0;
                        if (!push_hi_q) begin
                            pc_q <= tgt_q;
                            st_q <= iocx_pkg::ST_FETCH;
                        end
                    end
                    default: st_q <= iocx_pkg::ST_FETCH;
                endcase
            end
        end
    end

    assign count_q = regs_q[iocx_pkg::R_CNT];
    assign acc_q = regs_q[iocx_pkg::R_ACC];
    assign memory_pointer_pair_q = {regs_q[iocx_pkg::R_H],
        regs_q[iocx_pkg::R_L]};

    // A repeating block step returns to fetch once it runs with the count at one.
    a_block_repeat_stop: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (io_go && blk && blk_rep && count_q == iocx_pkg::CNT_ONE)
        |=> st_q == iocx_pkg::ST_FETCH)
        else $error("repeat did not stop at zero count");
    a_halt_holds: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (halted_q && !int_go) |=> halted_q)
        else $error("halt released without interrupt");
    a_mode1_jump: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (int_go && int_mode_q == iocx_pkg::IM_1)
        |=> ##2 pc_q == iocx_pkg::MODE1_TARGET)
        else $error("mode 1 did not reach fixed target");
    a_lock_opcode: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (take && st_q == iocx_pkg::ST_FETCH
            && instr_byte == iocx_pkg::OP_LOCK) |=> !int_enable_q)
        else $error("lockout ignored");
    a_imm_addr: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (io_go && op_q == iocx_pkg::OP_OUT_IMM)
        |=> io_wr_q && io_addr_q == {$past(acc_q), $past(veclo_q)})
        else $error("immediate address wrong");
    a_ind_addr: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (io_go && (blk || reg_in || reg_out))
        |=> io_addr_q[7:0] == $past(regs_q[iocx_pkg::R_PORT]))
        else $error("indirect port address wrong");
    a_block_count: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (io_go && blk) |=> count_q == $past(count_q) - iocx_pkg::CNT_ONE)
        else $error("count not decremented");
    a_mode_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (st_q != iocx_pkg::ST_PREFIX) |=> $stable(int_mode_q))
        else $error("mode changed without selection");

    // Two table reads at consecutive addresses follow a mode 2 acceptance.
    sequence s_table_reads;
        mem_rd_q ##1 (mem_rd_q
            && mem_addr_q == $past(mem_addr_q) + iocx_pkg::PTR_STEP);
    endsequence
    a_table_reads: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (int_go && int_mode_q == iocx_pkg::IM_2) |=> s_table_reads)
        else $error("vector table not read as two bytes");
endmodule // iocx_unit

// file: iocx_peer.sv
// Peripheral, memory and interrupter model facing the I/O unit.
`timescale 1ns/1ps
module iocx_peer (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic stall,
    input wire logic irq_go,
    input wire logic [7:0] vec_byte,
    input wire logic io_in_ready,
    input wire logic [15:0] mem_addr_q,
    input wire logic int_ack_q,
    output logic io_in_valid,
    output logic [7:0] io_in_data,
    output logic [7:0] mem_rd_data,
    output logic int_req,
    output logic [7:0] int_data
);
    logic [7:0] seq_q;
    // Input bytes count up from 10h; a stalled line shows junk, not data.
    assign io_in_valid = !stall;
    assign io_in_data = stall ? ~seq_q : seq_q;
    // Memory answers at once; each byte is its low address xor A5h.
    assign mem_rd_data = mem_addr_q[7:0] ^ 8'hA5;
    // The vector byte is only valid while a request is up or acknowledged.
    assign int_data = (int_req || int_ack_q) ? vec_byte
        : ~vec_byte;
    // Sequence advances only on an accepted byte.
    always_ff @(posedge ref_clk) begin
        if (sys_rst)
            seq_q <= 8'h10;
        else if (io_in_valid && io_in_ready)
            seq_q <= seq_q + 8'h01;
    end
    // The request is a level held until the unit acknowledges it.
    always_ff @(posedge ref_clk) begin
        if (sys_rst || int_ack_q)
            int_req <= 1'b0;
        else if (irq_go)
            int_req <= 1'b1;
    end
endmodule // iocx_peer

// file: tb.sv
// Self-checking bench for the I/O and CPU control unit.
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic [7:0] b0;
        logic [7:0] b1;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wd;
    } iocx_row_type;
    logic ref_clk, sys_rst, instr_valid, instr_ready, int_req, stall, irq_go;
    logic io_in_valid, io_in_ready, io_rd_q, io_wr_q, mem_rd_q, mem_wr_q;
    logic int_ack_q, halted_q, int_enable_q, last_wr;
    logic [7:0] instr_byte, int_data, vec_byte, io_in_data, mem_rd_data;
    logic [7:0] io_wdata_q, mem_wdata_q, count_q, acc_q, last_wd, nd, d, n;
    logic [15:0] io_addr_q, mem_addr_q, pc_q, memory_pointer_pair_q;
    logic [15:0] last_addr, p0;
    logic [1:0] int_mode_q;
    int fail_count = 0;
    int n_checks = 0;
    int n_memwr = 0;
    int n_iowr = 0;
    int n_ack = 0;
    int a;
    logic [7:0] bc [8] = '{8'hA2, 8'hB2, 8'hAA, 8'hBA, 8'hA3, 8'hB3, 8'hAB,
        8'hBB};
    logic [7:0] mc [3] = '{8'h46, 8'h56, 8'h5E};
    // Each row: two instruction bytes, direction, bus address, output data.
    iocx_row_type rows [15] = '{
        '{8'hDB, 8'h12, 1'b0, 16'h0012, 8'h00},
        '{8'hD3, 8'h34, 1'b1, 16'h1034, 8'h10},
        '{8'hED, 8'h40, 1'b0, 16'h0000, 8'h00},
        '{8'hED, 8'h48, 1'b0, 16'h1100, 8'h00},
        '{8'hED, 8'h79, 1'b1, 16'h1112, 8'h10},
        '{8'hED, 8'h41, 1'b1, 16'h1112, 8'h11},
        '{8'hED, 8'h49, 1'b1, 16'h1112, 8'h12},
        '{8'hED, 8'h50, 1'b0, 16'h1112, 8'h00},
        '{8'hED, 8'h51, 1'b1, 16'h1112, 8'h13},
        '{8'hED, 8'h58, 1'b0, 16'h1112, 8'h00},
        '{8'hED, 8'h59, 1'b1, 16'h1112, 8'h14},
        '{8'hED, 8'h60, 1'b0, 16'h1112, 8'h00},
        '{8'hED, 8'h61, 1'b1, 16'h1112, 8'h15},
        '{8'hED, 8'h68, 1'b0, 16'h1112, 8'h00},
        '{8'hED, 8'h69, 1'b1, 16'h1112, 8'h16}};

    iocx_unit i_iocx_unit (.ref_clk, .sys_rst, .instr_valid, .instr_ready,
        .instr_byte, .int_req, .int_data, .io_in_valid, .io_in_ready,
        .io_in_data, .mem_rd_data, .io_addr_q, .io_wdata_q, .io_rd_q,
        .io_wr_q, .mem_addr_q, .mem_wdata_q, .mem_rd_q, .mem_wr_q, .int_ack_q,
        .halted_q, .int_enable_q, .int_mode_q, .pc_q, .memory_pointer_pair_q,
        .count_q, .acc_q);
    iocx_peer i_iocx_peer (.ref_clk, .sys_rst, .stall, .irq_go, .vec_byte,
        .io_in_ready, .mem_addr_q, .int_ack_q, .io_in_valid, .io_in_data,
        .mem_rd_data, .int_req, .int_data);

    // Clock at 50 MHz.
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // Pulses are caught at the falling edge, where they have settled.
    always @(negedge ref_clk) begin
        if (io_rd_q === 1'b1 || io_wr_q === 1'b1) begin
            last_addr = io_addr_q;
            last_wd = io_wdata_q;
            last_wr = io_wr_q;
        end
        if (mem_wr_q === 1'b1) n_memwr++;
        if (io_wr_q === 1'b1) n_iowr++;
        if (int_ack_q === 1'b1) n_ack++;
    end

    task automatic tick(input int c);
        repeat (c) @(posedge ref_clk);
        #1;
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Bounded wait for the unit to accept bytes again.
    task automatic wait_ready();
        int k;
        k = 0;
        while (instr_ready !== 1'b1 && k < 2000) begin
            tick(1);
            k++;
        end
        if (k == 2000) begin
            fail_count++;
            conclude();
        end
    endtask

    // Valid stays high across both bytes so it never toggles in one step.
    task automatic op(input logic [7:0] b0, input logic [7:0] b1, input int nb);
        instr_valid = 1'b1;
        instr_byte = b0;
        wait_ready();
        tick(1);
        if (nb == 2) begin
            instr_byte = b1;
            wait_ready();
            tick(1);
        end
        instr_valid = 1'b0;
        if (b0 !== iocx_pkg::OP_HALT) begin
            tick(2);
            wait_ready();
            tick(2);
        end
    endtask

    task automatic wait_ack(input int a0);
        int k;
        k = 0;
        while (n_ack == a0 && k < 100) begin
            tick(1);
            k++;
        end
        if (k == 100) begin
            fail_count++;
            conclude();
        end
        tick(2);
        wait_ready();
        tick(2);
    endtask

    task automatic irq();
        irq_go = 1'b1;
        tick(1);
        irq_go = 1'b0;
    endtask

    // Main sequence: table of single transfers, then the awkward cases.
    initial begin
        sys_rst = 1'b1;
        instr_valid = 1'b0;
        instr_byte = 8'h00;
        stall = 1'b0;
        irq_go = 1'b0;
        vec_byte = 8'h20;
        tick(10);
        sys_rst = 1'b0;
        chk("state", 4'h0, {halted_q, int_enable_q, int_mode_q});
        for (int i = 0; i < 15; i++) begin
            last_addr = 16'hFFFF;
            op(rows[i].b0, rows[i].b1, 2);
            chk("io_addr", rows[i].addr, last_addr);
            chk("io_dir", rows[i].wr, last_wr);
            if (rows[i].wr)
                chk("io_wdata", rows[i].wd, last_wd);
        end
        chk("acc_cnt", 16'h1011, {acc_q, count_q});
        chk("pointer", 16'h1516, memory_pointer_pair_q);
        tick(4);
        chk("fifo_ready", 1'b0, io_in_ready);
        $display("test single transfers done");
        // Each block form runs on a freshly loaded count.
        nd = 8'h17;
        for (int i = 0; i < 8; i++) begin
            op(8'hED, 8'h40, 2);
            d = nd;
            nd = nd + 8'h01;
            n = bc[i][4] ? d : 8'h01;
            p0 = memory_pointer_pair_q;
            n_memwr = 0;
            n_iowr = 0;
            if (i == 1) begin
                stall = 1'b1;
                fork
                    begin
                        tick(40);
                        stall = 1'b0;
                    end
                join_none
            end
            op(8'hED, bc[i], 2);
            if (!bc[i][0])
                nd = nd + n;
            chk("pointer", bc[i][3] ? p0 - n : p0 + n,
                memory_pointer_pair_q);
            chk("count", d - n, count_q);
            chk("moves", n, bc[i][0] ? n_iowr : n_memwr);
        end
        $display("test block transfers done");
        for (int i = 0; i < 3; i++) begin
            op(8'hED, mc[i], 2);
            chk("mode", i, int_mode_q);
        end
        p0 = pc_q;
        op(8'h00, 8'h00, 1);
        chk("pc", p0 + 16'h0001, pc_q);
        chk("mode", 2'h2, int_mode_q);
        op(8'hF3, 8'h00, 1);
        chk("enable", 1'b0, int_enable_q);
        irq();
        tick(20);
        chk("acks", 0, n_ack);
        n_memwr = 0;
        op(8'hFB, 8'h00, 1);
        wait_ack(0);
        chk("pc", 16'h8485, pc_q);
        chk("pushes", 2, n_memwr);
        $display("test vectored interrupt done");
        op(8'hED, 8'h56, 2);
        op(8'hFB, 8'h00, 1);
        chk("enable", 1'b1, int_enable_q);
        op(8'h76, 8'h00, 1);
        tick(5);
        chk("halted", 1'b1, halted_q);
        chk("ready", 1'b0, instr_ready);
        n_memwr = 0;
        a = n_ack;
        irq();
        wait_ack(a);
        chk("halted", 1'b0, halted_q);
        chk("pc", 16'h0038, pc_q);
        chk("pushes", 2, n_memwr);
        $display("test halt and fixed interrupt done");
        op(8'hED, 8'h46, 2);
        op(8'hFB, 8'h00, 1);
        // The bus byte is a prefix; its second byte comes from the stream.
        vec_byte = 8'hED;
        a = n_ack;
        irq();
        wait_ack(a);
        chk("acks", a + 1, n_ack);
        chk("mode", 2'h0, int_mode_q);
        op(8'h56, 8'h00, 1);
        chk("mode", 2'h1, int_mode_q);
        $display("test bus instruction interrupt done");
        conclude();
    end
endmodule // tb
